//--- logic/cond_block_map.vh
// What this block does
// - The prefix makes one to four following instructions conditional.
// - First uses base condition; later ones use base or inverse per switch.
// - A breakpoint inside the block always executes, even on a false condition.
// - Exceptions inside a block save block state for the return info.
// - Exception return restores block state so the block resumes correctly.
// - The prefix instruction leaves the condition flags unchanged.
// - Base register program counter means table starts after the instruction.
// - Halfword table index shifts left by one; byte table index unshifted.
// - Branch offset is twice the zero-extended table entry.
// - Target is the address after the instruction plus the offset.
// - Table branches leave the condition flags unchanged.
`ifndef COND_BLOCK_MAP_VH
`define COND_BLOCK_MAP_VH
// Instruction kinds presented by fetch/decode
`define KIND_OTHER 3'h0
`define KIND_PREFIX 3'h1
`define KIND_TBB 3'h2
`define KIND_TBH 3'h3
`define KIND_BREAKPOINT_INSTR 3'h4
// Condition codes
`define COND_ALWAYS 4'hE
// Block state layout: [7:4] base cond, [3:0] mask
`define ST_COND_HI 7
`define ST_COND_LO 4
`define ST_MASK_HI 3
`define ST_MASK_LO 0
`define ST_RESET 8'h00
`define MASK_END 4'h8
// Table branch sequencer states
`define TB_IDLE 2'h0
`define TB_READ 2'h1
`define TB_WAIT 2'h2
// Instruction size of a table branch in bytes
`define TB_INSTR_BYTES 32'h00000004
`endif

//--- logic/cond_eval.v
`timescale 1ns/10ps
`include "cond_block_map.vh"
module cond_eval (
  // Condition and flags
  input wire [3:0] cond_i,
  input wire [3:0] flags_i,
  // Result
  output reg pass_o
);
  wire n_f;
  wire z_f;
  wire c_f;
  wire v_f;
  reg base;
  assign n_f = flags_i[3];
  assign z_f = flags_i[2];
  assign c_f = flags_i[1];
  assign v_f = flags_i[0];
  // Evaluate pair by top bits, invert on low bit except for 4'hF
  always @* begin
    case (cond_i[3:1])
      3'h0: base = z_f;
      3'h1: base = c_f;
      3'h2: base = n_f;
      3'h3: base = v_f;
      3'h4: base = c_f & ~z_f;
      3'h5: base = (n_f == v_f);
      3'h6: base = ~z_f & (n_f == v_f);
      default: base = 1'b1;
    endcase
    if (cond_i[0] && cond_i != 4'hF) begin
      pass_o = ~base;
    end else begin
      pass_o = base;
    end
  end
endmodule

//--- logic/cond_block_ctrl.v
`timescale 1ns/10ps
`include "cond_block_map.vh"
module cond_block_ctrl #(
  parameter AW = 32
) (
  // Clock, reset, enable
  input wire ref_clk_i,
  input wire nrst_i,
  input wire clk_en_i,
  // Decoded instruction from fetch
  input wire instr_valid_i,
  input wire [2:0] instr_kind_i,
  input wire [7:0] prefix_imm_i,
  input wire [AW-1:0] instr_addr_i,
  input wire base_is_pc_i,
  // Register file operands
  input wire [AW-1:0] base_val_i,
  input wire [AW-1:0] index_val_i,
  input wire [3:0] flags_i,
  // Exception entry and return
  input wire exc_entry_i,
  input wire exc_return_i,
  input wire [7:0] exc_state_i,
  // Table memory read port
  output reg mem_req_o,
  output reg [AW-1:0] mem_addr_o,
  output reg mem_half_o,
  input wire mem_ack_i,
  input wire [15:0] mem_data_i,
  // Execution control
  output reg exec_o,
  output reg busy_o,
  output reg in_block_o,
  output reg flags_we_o,
  output reg [7:0] saved_state_o,
  output reg branch_o,
  output reg [AW-1:0] branch_target_o
);
  reg [7:0] state_q;
  reg [7:0] state_d;
  reg [1:0] tb_q;
  reg [AW-1:0] next_addr_q;
  reg half_q;
  wire [3:0] cur_cond;
  wire cond_pass;
  wire active;
  wire [AW-1:0] tbl_base;
  wire [AW-1:0] tbl_off;
  wire [AW-1:0] after_addr;
  wire [AW-1:0] entry_x2;
  wire take;
  assign active = state_q[`ST_MASK_HI:`ST_MASK_LO] != 4'h0;
  assign cur_cond = state_q[`ST_COND_HI:`ST_COND_LO];
  assign after_addr = instr_addr_i + `TB_INSTR_BYTES;
  // Table base is after the instruction when base is pc
  assign tbl_base = base_is_pc_i ? after_addr : base_val_i;
  // Halfword index doubled, byte index used as is
  assign tbl_off = (instr_kind_i == `KIND_TBH) ?
    {index_val_i[AW-2:0], 1'b0} : index_val_i;
  // Zero-extended entry times two
  assign entry_x2 = half_q ? {{(AW-17){1'b0}}, mem_data_i, 1'b0} :
    {{(AW-9){1'b0}}, mem_data_i[7:0], 1'b0};
  assign take = instr_valid_i && tb_q == `TB_IDLE && clk_en_i;

  cond_eval u_eval (
    .cond_i(cur_cond),
    .flags_i(flags_i),
    .pass_o(cond_pass)
  );

  // Next block state: load on prefix, shift per block instruction
  always @* begin
    state_d = state_q;
    if (exc_return_i) begin
      state_d = exc_state_i;
    end else if (exc_entry_i) begin
      state_d = `ST_RESET;
    end else if (take) begin
      if (active) begin
        if (state_q[2:0] == 3'h0) begin
          state_d = `ST_RESET;
        end else begin
          state_d = {state_q[7:5], state_q[3],
            state_q[2:0], 1'b0};
        end
      end else if (instr_kind_i == `KIND_PREFIX) begin
        state_d = prefix_imm_i;
      end
    end
  end

  // Block state register
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= `ST_RESET;
      in_block_o <= 1'b0;
      saved_state_o <= `ST_RESET;
    end else if (clk_en_i) begin
      state_q <= state_d;
      in_block_o <= state_d[`ST_MASK_HI:`ST_MASK_LO] != 4'h0;
      if (exc_entry_i) begin
        saved_state_o <= state_q;
      end
    end
  end

  // Execute decision and table branch sequencer
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tb_q <= `TB_IDLE;
      exec_o <= 1'b0;
      busy_o <= 1'b0;
      flags_we_o <= 1'b0;
      mem_req_o <= 1'b0;
      mem_addr_o <= {AW{1'b0}};
      mem_half_o <= 1'b0;
      branch_o <= 1'b0;
      branch_target_o <= {AW{1'b0}};
      next_addr_q <= {AW{1'b0}};
      half_q <= 1'b0;
    end else if (clk_en_i) begin
      exec_o <= 1'b0;
      flags_we_o <= 1'b0;
      branch_o <= 1'b0;
      case (tb_q)
        `TB_IDLE: begin
          if (instr_valid_i && !exc_entry_i && !exc_return_i) begin
            if (instr_kind_i == `KIND_BREAKPOINT_INSTR) begin
              exec_o <= 1'b1;
            end else if (!active || cond_pass) begin
              exec_o <= 1'b1;
              // Prefix and table branches keep flags
              flags_we_o <= instr_kind_i == `KIND_OTHER;
              if (instr_kind_i == `KIND_TBB ||
                  instr_kind_i == `KIND_TBH) begin
                tb_q <= `TB_READ;
                busy_o <= 1'b1;
                mem_req_o <= 1'b1;
                mem_addr_o <= tbl_base + tbl_off;
                mem_half_o <= instr_kind_i == `KIND_TBH;
                half_q <= instr_kind_i == `KIND_TBH;
                next_addr_q <= after_addr;
              end
            end
          end
        end
        `TB_READ: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            tb_q <= `TB_WAIT;
            branch_o <= 1'b1;
            // Forward target from following address
            branch_target_o <= next_addr_q + entry_x2;
          end
        end
        `TB_WAIT: begin
          busy_o <= 1'b0;
          tb_q <= `TB_IDLE;
        end
        default: tb_q <= `TB_IDLE;
      endcase
    end
  end
endmodule

//--- test/cond_block_props.sv
`timescale 1ns/10ps
module cond_block_props #(
  parameter AW = 32
) (
  // Watched ports
  input wire ref_clk_i, nrst_i, clk_en_i, instr_valid_i, base_is_pc_i,
  input wire [2:0] instr_kind_i,
  input wire [7:0] prefix_imm_i, exc_state_i, saved_state_o,
  input wire [AW-1:0] instr_addr_i, base_val_i, index_val_i,
  input wire exc_entry_i, exc_return_i, mem_ack_i, mem_req_o,
  input wire [15:0] mem_data_i,
  input wire [AW-1:0] mem_addr_o, branch_target_o,
  input wire exec_o, busy_o, in_block_o, flags_we_o, branch_o
);
  // Accepted instruction and table address expected for it
  wire take = clk_en_i && instr_valid_i && !busy_o && !exc_entry_i
    && !exc_return_i;
  wire tb_take = take && instr_kind_i[2:1] == 2'h1;
  wire [AW-1:0] nxt = instr_addr_i + 4;
  wire [AW-1:0] ea = (base_is_pc_i ? nxt : base_val_i)
    + (instr_kind_i[0] ? index_val_i << 1 : index_val_i);
  reg [AW-1:0] nxt_q;
  reg half_q;
  // Keeps the following address and entry size of the table branch in flight
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nxt_q <= {AW{1'b0}};
      half_q <= 1'b0;
    end else if (tb_take) begin
      nxt_q <= nxt;
      half_q <= instr_kind_i[0];
    end
  end
  wire [AW-1:0] et = nxt_q + (half_q ? {mem_data_i, 1'b0}
    : {mem_data_i[7:0], 1'b0});
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_BREAKPOINT_INSTR_RUNS: assert property (
    take && instr_kind_i == 3'h4 |=> exec_o) else $error("breakpoint_instr skipped");
  AST_NO_FLAGS: assert property (
    take && instr_kind_i != 3'h0 |=> !flags_we_o) else $error("flags hit");
  AST_TB_ADDR: assert property (
    tb_take |=> mem_req_o && mem_addr_o == $past(ea)) else $error("addr");
  AST_TB_TGT: assert property (
    mem_req_o && mem_ack_i && clk_en_i |=> branch_o
      && branch_target_o == $past(et)) else $error("target");
  AST_OPEN: assert property (
    take && instr_kind_i == 3'h1 && prefix_imm_i[3:0] != 4'h0
      |=> in_block_o) else $error("block not opened");
  AST_CLOSE: assert property (
    take && instr_kind_i == 3'h1 && prefix_imm_i[3:0] == 4'h8
      ##1 !instr_valid_i && !exc_return_i ##1 take && instr_kind_i != 3'h1
      |=> !in_block_o) else $error("block not closed");
  AST_EXC_SAVE: assert property (
    clk_en_i && exc_entry_i && !exc_return_i && in_block_o
      |=> !in_block_o && saved_state_o[3:0] != 4'h0) else $error("save");
  AST_EXC_BACK: assert property (
    clk_en_i && exc_return_i && exc_state_i[2:0] != 3'h0 |=> in_block_o)
    else $error("resume");
endmodule
bind cond_block_ctrl cond_block_props #(.AW(AW)) i_cond_block_props (.*);

//--- test/test_cond_block_ctrl.sv
`timescale 1ns/10ps
module test_cond_block_ctrl;
  reg ref_clk_i = 1'b0, nrst_i = 1'b0, clk_en_i = 1'b1, instr_valid_i = 1'b0;
  reg base_is_pc_i = 1'b0, exc_entry_i = 1'b0, exc_return_i = 1'b0;
  reg mem_ack_i = 1'b0;
  reg [2:0] instr_kind_i = 3'h0;
  reg [7:0] prefix_imm_i = 8'h00, exc_state_i = 8'h00;
  reg [31:0] instr_addr_i = 32'h0, base_val_i = 32'h0, index_val_i = 32'h0;
  reg [31:0] s = 32'h0001491E;
  reg [15:0] mem_data_i = 16'h0;
  reg [3:0] flags_i = 4'h4;
  wire mem_req_o, mem_half_o, exec_o, busy_o, in_block_o, flags_we_o;
  wire branch_o;
  wire [31:0] mem_addr_o, branch_target_o;
  wire [7:0] saved_state_o;
  integer fail_count = 0, check_count = 0, cyc = 0, i;
  cond_block_ctrl i_cond_block_ctrl (.*);
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task issue(input [2:0] k, input [7:0] imm, input ex);
    begin
      @(negedge ref_clk_i);
      instr_valid_i = 1'b1;
      instr_kind_i = k;
      prefix_imm_i = imm;
      @(negedge ref_clk_i);
      instr_valid_i = 1'b0;
      if (k != 3'h1) chk(exec_o, ex);
      chk(flags_we_o, ex && k == 3'h0);
    end
  endtask
  // Random table branch with a random table entry
  task tbr(input [2:0] k);
    begin
      base_is_pc_i = s[0];
      base_val_i = lfsr(s);
      index_val_i = s[9:2];
      instr_addr_i = {s[31:2], 2'h0};
      s = lfsr(base_val_i);
      issue(k, 8'h00, 1'b1);
      chk(mem_half_o, k[0]);
      chk(busy_o, 1'b1);
      chk(mem_req_o, 1'b1);
      chk(mem_addr_o, (base_is_pc_i ? instr_addr_i + 4 : base_val_i)
        + (k[0] ? index_val_i << 1 : index_val_i));
      mem_data_i = s[15:0];
      mem_ack_i = 1'b1;
      @(negedge ref_clk_i);
      mem_ack_i = 1'b0;
      chk(branch_o, 1'b1);
      chk(mem_req_o, 1'b0);
      chk(branch_target_o, instr_addr_i + 4 + (k[0] ? {s[15:0], 1'b0}
        : {s[7:0], 1'b0}));
      @(negedge ref_clk_i);
      chk(busy_o, 1'b0);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Clock and run limit
  initial forever #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      fail_count = fail_count + 1;
      finish_test;
    end
  end
  // Table branches, then blocks with equal flag set
  initial begin
    repeat (3) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    for (i = 0; i < 12; i = i + 1) tbr(3'h2 + s[8]);
    issue(3'h1, 8'h06, 1'b0);
    issue(3'h0, 8'h00, 1'b1);
    issue(3'h0, 8'h00, 1'b1);
    issue(3'h0, 8'h00, 1'b0);
    chk(in_block_o, 1'b0);
    // Single instruction block closes after one
    issue(3'h1, 8'h08, 1'b0);
    issue(3'h0, 8'h00, 1'b1);
    chk(in_block_o, 1'b0);
    issue(3'h1, 8'h0C, 1'b0);
    issue(3'h0, 8'h00, 1'b1);
    issue(3'h4, 8'h00, 1'b1);
    issue(3'h1, 8'h06, 1'b0);
    issue(3'h0, 8'h00, 1'b1);
    exc_entry_i = 1'b1;
    @(negedge ref_clk_i);
    exc_entry_i = 1'b0;
    chk(saved_state_o, 8'h0C);
    exc_state_i = 8'h0C;
    exc_return_i = 1'b1;
    @(negedge ref_clk_i);
    exc_return_i = 1'b0;
    chk(in_block_o, 1'b1);
    issue(3'h0, 8'h00, 1'b1);
    issue(3'h0, 8'h00, 1'b0);
    chk(in_block_o, 1'b0);
    // Reset in mid block, then plain execution
    issue(3'h1, 8'h06, 1'b0);
    nrst_i = 1'b0;
    @(negedge ref_clk_i);
    nrst_i = 1'b1;
    chk(in_block_o, 1'b0);
    chk(saved_state_o, 8'h00);
    issue(3'h0, 8'h00, 1'b1);
    finish_test;
  end
endmodule
